// ### inc/dvitx_map.vh
`ifndef DVITX_MAP_VH
`define DVITX_MAP_VH

// ----------------------------------------------------------------
// register byte offsets (haddr[7:0])
// ----------------------------------------------------------------
`define DVITX_CTRL_OFF 8'h00
`define DVITX_STAT_OFF 8'h04
`define DVITX_SCNT_OFF 8'h08
`define DVITX_DEC_MSB 7

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DVITX_CTRL_PWR 0
`define DVITX_CTRL_SRST 1
`define DVITX_PWR_RST 1'h0

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define DVITX_ST_PD 0
`define DVITX_ST_CONFIG_INTERFACE_SELECT 1
`define DVITX_ST_PIN 2
`define DVITX_ST_FULL 3
`define DVITX_ST_EMPTY 4
`define DVITX_ST_STRAP 5

// ----------------------------------------------------------------
// bus constants
// ----------------------------------------------------------------
`define DVITX_HTRANS_NONSEQ 2'h2
`define DVITX_HTRANS_SEQ 2'h3
`define DVITX_HRESP_OKAY 1'h0
`define DVITX_ZERO32 32'h0000_0000
`define DVITX_ZERO16 16'h0000
`define DVITX_ONE16 16'h0001

// ----------------------------------------------------------------
// pixel word layout in the fifo
// ----------------------------------------------------------------
`define DVITX_W_BLU_LSB 0
`define DVITX_W_GRN_LSB 8
`define DVITX_W_RED_LSB 16
`define DVITX_W_DE 24
`define DVITX_W_HS 25
`define DVITX_W_VS 26
`define DVITX_W_CTL1 27
`define DVITX_W_CTL2 28
`define DVITX_W_CTL3 29
`define DVITX_W_BITS 30
`define DVITX_ZERO_W 30'h0000_0000

// ----------------------------------------------------------------
// channel symbol layout
// ----------------------------------------------------------------
`define DVITX_CH_BITS 10
`define DVITX_CH_VID 9
`define DVITX_ZERO_CH 10'h000
`define DVITX_FIFO_DEPTH 16
`define DVITX_FIFO_AW 4

`endif

// ### logic/dvitx_fifo.v
`timescale 1ns/1ps
`include "dvitx_map.vh"

module dvitx_fifo
#(
   parameter W = `DVITX_W_BITS,
   parameter D = `DVITX_FIFO_DEPTH,
   parameter AW = `DVITX_FIFO_AW
)
(
   // clock and reset
   input wire hclk,
   input wire hresetn,
   input wire flush,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data,
   // level
   output wire full,
   output wire empty
);

reg [W-1:0] mem_q [0:D-1];
reg [AW-1:0] wr_q;
reg [AW-1:0] rd_q;
reg [AW:0] cnt_q;
wire push;
wire pop;

assign full = (cnt_q == D[AW:0]);
assign empty = (cnt_q == {(AW+1){1'b0}});
assign in_ready = ~full;
assign out_valid = ~empty;
assign out_data = mem_q[rd_q];
assign push = in_valid & ~full;
assign pop = out_ready & ~empty;

always @(posedge hclk)
begin
   if (push)
      mem_q[wr_q] <= in_data;
end

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
   end
   else if (flush)
   begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
   end
   else
   begin
      if (push)
         wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
         rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
         cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
         cnt_q <= cnt_q - 1'b1;
   end
end

endmodule // dvitx_fifo

// ### logic/dvitx_top.v
// Summary of operation
// - interface off: power_down_n high runs normally, low powers down
// - interface on: power state comes from the register bit, not the pin
// - power bit resets low; powered down on enabling or soft reset
// - blue channel: blue pixel bits in video, hsync and vsync in blanking
// - green channel: green pixel bits in video, control bit 1 in blanking
// - red channel: red pixel bits in video, control bits 3:2 in blanking
// - separate differential pair carries the link clock
// - select high enables config interface, low makes pins straps
// - power-down keeps only i/o and config interface alive
`timescale 1ns/1ps
`include "dvitx_map.vh"

module dvitx_top
#(
   parameter FIFO_DEPTH = `DVITX_FIFO_DEPTH,
   parameter FIFO_AW = `DVITX_FIFO_AW
)
(
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // straps
   input wire config_interface_select,
   input wire power_down_n,
   // pixel input from graphics controller
   input wire pixel_strobe,
   input wire [23:0] pixel_data,
   input wire pixel_de,
   input wire pixel_hsync,
   input wire pixel_vsync,
   input wire [3:1] blanking_control_bits,
   output wire pixel_ready,
   // link side
   input wire link_clk,
   output reg [9:0] blue_channel_pair,
   output reg [9:0] green_channel_pair,
   output reg [9:0] red_channel_pair,
   output reg link_clock_pair_p,
   output reg link_clock_pair_n,
   output wire powered_down
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg config_interface_select_m_q;
reg config_interface_select_s_q;
reg config_interface_select_e_q;
reg pdn_m_q;
reg pdn_s_q;
reg lclk_m_q;
reg lclk_s_q;
reg lclk_e_q;
reg stb_m_q;
reg stb_s_q;
reg stb_e_q;
reg [`DVITX_W_BITS-1:0] pix_m_q;
reg [`DVITX_W_BITS-1:0] pix_s_q;
wire [`DVITX_W_BITS-1:0] pix_raw;

assign pix_raw = {blanking_control_bits, pixel_vsync, pixel_hsync,
                  pixel_de, pixel_data};

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      config_interface_select_m_q <= 1'b0;
      config_interface_select_s_q <= 1'b0;
      config_interface_select_e_q <= 1'b0;
      pdn_m_q <= 1'b0;
      pdn_s_q <= 1'b0;
      lclk_m_q <= 1'b0;
      lclk_s_q <= 1'b0;
      lclk_e_q <= 1'b0;
      stb_m_q <= 1'b0;
      stb_s_q <= 1'b0;
      stb_e_q <= 1'b0;
      pix_m_q <= `DVITX_ZERO_W;
      pix_s_q <= `DVITX_ZERO_W;
   end
   else
   begin
      config_interface_select_m_q <= config_interface_select;
      config_interface_select_s_q <= config_interface_select_m_q;
      config_interface_select_e_q <= config_interface_select_s_q;
      pdn_m_q <= power_down_n;
      pdn_s_q <= pdn_m_q;
      lclk_m_q <= link_clk;
      lclk_s_q <= lclk_m_q;
      lclk_e_q <= lclk_s_q;
      stb_m_q <= pixel_strobe;
      stb_s_q <= stb_m_q;
      stb_e_q <= stb_s_q;
      pix_m_q <= pix_raw;
      pix_s_q <= pix_m_q;
   end
end

wire config_interface_select_rise;
wire lclk_rise;
wire stb_rise;

assign config_interface_select_rise = config_interface_select_s_q & ~config_interface_select_e_q;
assign lclk_rise = lclk_s_q & ~lclk_e_q;
assign stb_rise = stb_s_q & ~stb_e_q;

// ----------------------------------------------------------------
// ahb-lite slave, zero wait states
// ----------------------------------------------------------------
reg wr_pend_q;
reg [`DVITX_DEC_MSB:0] wr_addr_q;
reg pwr_on_q;
reg [15:0] sym_cnt_q;
wire addr_phase;
wire wr_take;
wire rd_take;
wire ctrl_wr;
wire [31:0] ctrl_rd;
wire [31:0] stat_rd;
wire fifo_full;
wire fifo_empty;
wire pd_eff;
reg [31:0] rd_mux;

assign hreadyout = 1'b1;
assign hresp = `DVITX_HRESP_OKAY;
assign addr_phase = hsel & hready &
                    ((htrans == `DVITX_HTRANS_NONSEQ) |
                     (htrans == `DVITX_HTRANS_SEQ));
assign wr_take = addr_phase & hwrite;
assign rd_take = addr_phase & ~hwrite;
// writes only land while the config interface is enabled
assign ctrl_wr = wr_pend_q & config_interface_select_s_q &
                 (wr_addr_q == `DVITX_CTRL_OFF);

assign ctrl_rd = {31'h0000_0000, pwr_on_q};
assign stat_rd = {26'h000_0000,
                  config_interface_select_s_q & pdn_s_q,
                  fifo_empty,
                  fifo_full,
                  pdn_s_q,
                  config_interface_select_s_q,
                  pd_eff};

always @*
begin
   case (haddr[`DVITX_DEC_MSB:0])
      `DVITX_CTRL_OFF: rd_mux = ctrl_rd;
      `DVITX_STAT_OFF: rd_mux = stat_rd;
      `DVITX_SCNT_OFF: rd_mux = {16'h0000, sym_cnt_q};
      default: rd_mux = `DVITX_ZERO32;
   endcase
end

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= `DVITX_ZERO32;
   end
   else
   begin
      wr_pend_q <= wr_take;
      if (wr_take)
         wr_addr_q <= haddr[`DVITX_DEC_MSB:0];
      if (rd_take)
         hrdata <= rd_mux;
   end
end

// ----------------------------------------------------------------
// power-down control
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
      pwr_on_q <= `DVITX_PWR_RST;
   else if (config_interface_select_rise)
      pwr_on_q <= `DVITX_PWR_RST;
   else if (ctrl_wr & hwdata[`DVITX_CTRL_SRST])
      pwr_on_q <= `DVITX_PWR_RST;
   else if (ctrl_wr)
      pwr_on_q <= hwdata[`DVITX_CTRL_PWR];
end

// pin ignored while interface is on; bit ignored while off
assign pd_eff = config_interface_select_s_q ? ~pwr_on_q : ~pdn_s_q;
assign powered_down = pd_eff;

// ----------------------------------------------------------------
// pixel buffer
// ----------------------------------------------------------------
wire fifo_in_valid;
wire fifo_in_ready;
wire fifo_out_valid;
wire fifo_out_ready;
wire [`DVITX_W_BITS-1:0] fifo_out_data;

// buffer is flushed and refuses input while powered down
assign fifo_in_valid = stb_rise & ~pd_eff;
assign pixel_ready = fifo_in_ready & ~pd_eff;
assign fifo_out_ready = lclk_rise & ~pd_eff;

dvitx_fifo
#(
   .W(`DVITX_W_BITS),
   .D(FIFO_DEPTH),
   .AW(FIFO_AW)
)
u_fifo
(
   .hclk(hclk),
   .hresetn(hresetn),
   .flush(pd_eff),
   .in_valid(fifo_in_valid),
   .in_ready(fifo_in_ready),
   .in_data(pix_s_q),
   .out_valid(fifo_out_valid),
   .out_ready(fifo_out_ready),
   .out_data(fifo_out_data),
   .full(fifo_full),
   .empty(fifo_empty)
);

// ----------------------------------------------------------------
// channel mapping
// ----------------------------------------------------------------
wire [`DVITX_W_BITS-1:0] wrd;
wire vid;
reg [9:0] blu_d;
reg [9:0] grn_d;
reg [9:0] red_d;

// an empty buffer sends a blanking word with all controls low
assign wrd = fifo_out_valid ? fifo_out_data : `DVITX_ZERO_W;
assign vid = wrd[`DVITX_W_DE];

always @*
begin
   blu_d = `DVITX_ZERO_CH;
   grn_d = `DVITX_ZERO_CH;
   red_d = `DVITX_ZERO_CH;
   if (vid)
   begin
      blu_d = {1'b1, 1'b0,
               wrd[`DVITX_W_BLU_LSB+7:`DVITX_W_BLU_LSB]};
      grn_d = {1'b1, 1'b0,
               wrd[`DVITX_W_GRN_LSB+7:`DVITX_W_GRN_LSB]};
      red_d = {1'b1, 1'b0,
               wrd[`DVITX_W_RED_LSB+7:`DVITX_W_RED_LSB]};
   end
   else
   begin
      blu_d[1:0] = {wrd[`DVITX_W_VS], wrd[`DVITX_W_HS]};
      grn_d[0] = wrd[`DVITX_W_CTL1];
      red_d[1:0] = {wrd[`DVITX_W_CTL3], wrd[`DVITX_W_CTL2]};
   end
end

// ----------------------------------------------------------------
// link outputs
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      blue_channel_pair <= `DVITX_ZERO_CH;
      green_channel_pair <= `DVITX_ZERO_CH;
      red_channel_pair <= `DVITX_ZERO_CH;
      link_clock_pair_p <= 1'b0;
      link_clock_pair_n <= 1'b0;
      sym_cnt_q <= `DVITX_ZERO16;
   end
   else if (pd_eff)
   begin
      // outputs quiet, clock pair stopped
      blue_channel_pair <= `DVITX_ZERO_CH;
      green_channel_pair <= `DVITX_ZERO_CH;
      red_channel_pair <= `DVITX_ZERO_CH;
      link_clock_pair_p <= 1'b0;
      link_clock_pair_n <= 1'b0;
   end
   else
   begin
      link_clock_pair_p <= lclk_s_q;
      link_clock_pair_n <= ~lclk_s_q;
      if (lclk_rise)
      begin
         blue_channel_pair <= blu_d;
         green_channel_pair <= grn_d;
         red_channel_pair <= red_d;
         if (fifo_out_valid)
            sym_cnt_q <= sym_cnt_q + `DVITX_ONE16;
      end
   end
end

endmodule // dvitx_top

// ### tb/dvi_tx_powerdown_channel_map_tb.sv
`timescale 1ns/1ps
`include "dvitx_map.vh"
module dvi_tx_powerdown_channel_map_tb;
   localparam logic [31:0] ctrl_a = {24'h00_0000, `DVITX_CTRL_OFF};
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic config_interface_select = 1'b0, power_down_n = 1'b0, run = 1'b0;
   logic pixel_strobe = 1'b0, pixel_de = 1'b0;
   logic pixel_hsync = 1'b0, pixel_vsync = 1'b0;
   logic [23:0] pixel_data = 24'h00_0000;
   logic [3:1] blanking_control_bits = 3'h0;
   logic hready, hreadyout, hresp, pixel_ready, link_clk, powered_down;
   logic [31:0] hrdata;
   logic [9:0] blue_channel_pair, green_channel_pair, red_channel_pair;
   logic link_clock_pair_p, link_clock_pair_n;
   logic [29:0] w, exp_q[$];
   int unsigned seed;
   int errors = 0, check_count = 0;
   assign hready = hreadyout;
   always #20 hclk = ~hclk;
   dvitx_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata,
      .config_interface_select, .power_down_n, .pixel_strobe, .pixel_data,
      .pixel_de, .pixel_hsync, .pixel_vsync, .blanking_control_bits,
      .pixel_ready, .link_clk, .blue_channel_pair, .green_channel_pair,
      .red_channel_pair, .link_clock_pair_p, .link_clock_pair_n,
      .powered_down);
   dvitx_rx_model rx (.run, .link_clk, .blue_channel_pair,
      .green_channel_pair, .red_channel_pair);
   task chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task chk_sym(input string n, input logic [29:0] e, g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= `DVITX_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      chk("hresp", 32'h0000_0000, hresp);
   endtask
   task push_px(input logic [29:0] v);
      @(posedge hclk);
      {blanking_control_bits, pixel_vsync, pixel_hsync, pixel_de,
         pixel_data} <= v;
      repeat (3) @(posedge hclk);
      pixel_strobe <= 1'b1;
      repeat (4) @(posedge hclk);
      pixel_strobe <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   function logic [29:0] exp_sym(input logic [29:0] v);
      if (v[24])
         return {2'h2, v[23:16], 2'h2, v[15:8], 2'h2, v[7:0]};
      return {8'h00, v[29:28], 9'h000, v[27], 8'h00, v[26:25]};
   endfunction
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge hclk);
      errors++;
      report_and_stop;
   end
   initial
   begin
      seed = $urandom(32'h4b6a);
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      chk("pd pin low", 1, powered_down);
      power_down_n <= 1'b1;
      repeat (6) @(posedge hclk);
      chk("pd pin high", 0, powered_down);
      // link still: fill past depth, last word dropped
      for (int i = 0; i < 17; i++)
      begin
         w = i == 0 ? 30'h3e00_0000 : i == 1 ? 30'h01ff_ffff : 30'($urandom);
         push_px(w);
         if (i < 16)
            exp_q.push_back(exp_sym(w));
      end
      chk("ready full", 0, pixel_ready);
      exp_q.push_back(30'h0000_0000);
      run <= 1'b1;
      repeat (152) @(posedge hclk);
      run <= 1'b0;
      repeat (16) @(posedge hclk);
      foreach (exp_q[i])
         chk_sym("symbol", exp_q[i], rx.rx_q[i]);
      power_down_n <= 1'b0;
      bus(1'b1, ctrl_a, 32'h0000_0001, rd);
      bus(1'b0, ctrl_a, 32'h0000_0000, rd);
      chk("ctrl select low", 0, rd);
      config_interface_select <= 1'b1;
      repeat (8) @(posedge hclk);
      chk("pd on enable", 1, powered_down);
      bus(1'b1, ctrl_a, 32'h0000_0001, rd);
      repeat (3) @(posedge hclk);
      chk("run by register", 0, powered_down);
      // re-enable with the power bit set: must power down again
      power_down_n <= 1'b1;
      config_interface_select <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("pd select off", 0, powered_down);
      config_interface_select <= 1'b1;
      power_down_n <= 1'b0;
      repeat (8) @(posedge hclk);
      chk("pd re-enable", 1, powered_down);
      bus(1'b1, ctrl_a, 32'h0000_0001, rd);
      repeat (3) @(posedge hclk);
      chk("run again", 0, powered_down);
      bus(1'b1, ctrl_a, 32'h0000_0003, rd);
      bus(1'b0, ctrl_a, 32'h0000_0000, rd);
      chk("ctrl soft reset", 0, rd);
      chk("pd soft reset", 1, powered_down);
      bus(1'b0, 32'h0000_00fc, 32'h0000_0000, rd);
      chk("unmapped read", 0, rd);
      // powered down, select on, pin low, buffer flushed
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
      chk("status", 32'h0000_0013, rd);
      // one count per buffered word sent on the link
      bus(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
      chk("symbol count", 32'h0000_0010, rd);
      report_and_stop;
   end
endmodule // dvi_tx_powerdown_channel_map_tb

// ### tb/dvitx_rx_model.sv
`timescale 1ns/1ps
module dvitx_rx_model
(
   // control
   input wire logic run,
   // link
   output wire logic link_clk,
   input wire logic [9:0] blue_channel_pair,
   input wire logic [9:0] green_channel_pair,
   input wire logic [9:0] red_channel_pair
);
   logic [29:0] rx_q[$];
   // starts low without a time-zero edge, so no stray symbol
   logic lclk_q = 1'b0;
   assign link_clk = lclk_q;
   // clock stands low between frames
   always #160
      if (run || lclk_q)
         lclk_q = ~lclk_q;
   // take symbols mid period, once settled
   always @(negedge lclk_q)
      rx_q.push_back({red_channel_pair, green_channel_pair,
         blue_channel_pair});
endmodule // dvitx_rx_model

// ### tb/dvitx_top_asserts.sv
`timescale 1ns/1ps
module dvitx_top_asserts
(
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // bus
   input wire hsel,
   // straps
   input wire config_interface_select,
   input wire power_down_n,
   // outputs
   input wire pixel_ready,
   input wire [9:0] blue_channel_pair,
   input wire [9:0] green_channel_pair,
   input wire [9:0] red_channel_pair,
   input wire link_clock_pair_p,
   input wire link_clock_pair_n,
   input wire powered_down
);
   wire [9:0] b = blue_channel_pair;
   wire [9:0] g = green_channel_pair;
   wire [9:0] r = red_channel_pair;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_pin_pdown: assert property (
      (!config_interface_select && !power_down_n) [*4] |-> powered_down)
      else $error("pin low ran");
   chk_pin_run: assert property (
      (!config_interface_select && power_down_n) [*4] |-> !powered_down)
      else $error("pin high powered down");
   chk_reg_hold: assert property (
      config_interface_select [*6] ##0 !hsel && !$past(hsel, 1)
      && !$past(hsel, 2) && !$past(hsel, 3) |-> $stable(powered_down))
      else $error("power moved without a write");
   chk_enable_pdown: assert property (
      $rose(config_interface_select) |-> ##[1:5] powered_down)
      else $error("enable did not power down");
   chk_blue_fmt: assert property (
      b[9] ? !b[8] : b[9:2] == 8'h00)
      else $error("blue symbol malformed");
   chk_green_fmt: assert property (
      g[9] == b[9] && (g[9] ? !g[8] : g[9:1] == 9'h000))
      else $error("green symbol malformed");
   chk_red_fmt: assert property (
      r[9] == b[9] && (r[9] ? !r[8] : r[9:2] == 8'h00))
      else $error("red symbol malformed");
   chk_clk_pair: assert property (
      (!powered_down) [*3] |-> link_clock_pair_n != link_clock_pair_p)
      else $error("clock pair not complementary");
   chk_pdown_quiet: assert property (
      powered_down [*2] |-> {b, g, r, link_clock_pair_p,
      link_clock_pair_n} == 32'h0000_0000)
      else $error("link active in power-down");
   chk_pdown_refuse: assert property (
      powered_down |-> !pixel_ready)
      else $error("ready in power-down");
   cover property ($rose(config_interface_select));
   cover property (b[9]);
   cover property ($fell(pixel_ready) && !powered_down);
endmodule // dvitx_top_asserts

bind dvitx_top dvitx_top_asserts chk (.hclk, .hresetn, .hsel,
   .config_interface_select, .power_down_n, .pixel_ready,
   .blue_channel_pair, .green_channel_pair, .red_channel_pair,
   .link_clock_pair_p, .link_clock_pair_n, .powered_down);
